// >>> verilog/itmc_checker.sv
// top: ingress tlp malformed checker and config request front end for one port
`timescale 1ns/100ps
module itmc_checker
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // port identity
   input wire logic [1:0] port_id,
   // express device control payload field (max_payload_field)
   input wire logic [2:0] max_payload_field,
   // received tlp stream, one dword per beat, from the link
   input wire logic rx_valid,
   input wire logic rx_sop,
   input wire logic rx_eop,
   input wire logic [31:0] rx_data,
   // verdict
   output logic tlp_done,
   output logic tlp_malformed,
   output logic fatal_err,
   // config requests toward the bridge registers
   output logic cfg_req,
   output logic cfg_write,
   output logic [15:0] cfg_tag,
   output logic cfg_drop,
   input wire logic cfg_done,
   output logic [15:0] cfg_head_tag,
   output logic cfg_head_valid,
   // capability layout
   output logic has_switch_regs,
   output logic has_msi_cap
);
   itmc_pkg::itmc_state_t state_r;
   itmc_pkg::itmc_state_t state_nxt;
   logic [6:0] ft_r;
   logic [9:0] len_r;
   logic [2:0] tc_r;
   logic [1:0] attr_r;
   logic dig_r;
   logic [7:0] code_r;
   logic [15:0] tag_r;
   logic [11:0] cnt_r;
   logic done_r;
   logic bad_r;
   logic fatal_r;
   logic creq_r;
   logic cwr_r;
   logic [15:0] ctag_r;
   logic drop_r;
   logic htag_valid_r;
   logic [15:0] htag_r;
   logic sw_r;
   logic msi_r;
   logic [2:0] mps_r;
   logic len_bad;
   logic trk_drop;
   logic trk_hv;
   logic [15:0] trk_ht;
   logic [2:0] trk_cnt;
   wire beat = rx_valid;
   wire first = beat && rx_sop;
   // beat 2 carries requester id/tag and message code
   wire beat2 = beat && !rx_sop && cnt_r == 12'h001;
   wire last = beat && rx_eop;
   wire [11:0] limit_dw = 12'h080 << mps_r;
   wire is_cfg0 = ft_r == itmc_pkg::ITMC_CFGRD0 || ft_r == itmc_pkg::ITMC_CFGWR0;
   wire single = first && rx_eop;
   // latched header fields are used at eop; single-beat tlp uses raw bits
   wire [6:0] ft_use = first ? rx_data[30:24] : ft_r;
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         itmc_pkg::ITMC_IDLE: if (first && !rx_eop) state_nxt = itmc_pkg::ITMC_BODY;
         itmc_pkg::ITMC_BODY: if (last) state_nxt = itmc_pkg::ITMC_IDLE;
         default: state_nxt = itmc_pkg::ITMC_IDLE;
      endcase
   end
   // only this port's receive stream is checked
   itmc_len_rule u_rule
   (
      .fmt_type(ft_use),
      .length(first ? rx_data[9:0] : len_r),
      .tc(first ? rx_data[22:20] : tc_r),
      .attr(first ? rx_data[13:12] : attr_r),
      .digest(first ? rx_data[15] : dig_r),
      .msg_code(code_r),
      .dw_count(cnt_r + 12'h001),
      .limit_dw(limit_dw),
      .bad(len_bad)
   );
   wire eval = last && (state_r == itmc_pkg::ITMC_BODY || single);
   wire ok_cfg = eval && !len_bad && is_cfg0 && !single;
   // well formed type 0 config goes to bridge registers unless four are already tracked, then it is dropped
   itmc_cfg_track u_trk
   (
      .clk(clk),
      .rst_n(rst_n),
      .req_push(ok_cfg),
      .req_tag(tag_r),
      .req_drop(trk_drop),
      .done(cfg_done),
      .head_valid(trk_hv),
      .head_tag(trk_ht),
      .count(trk_cnt)
   );
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         state_r <= itmc_pkg::ITMC_IDLE;
         ft_r <= 7'h00;
         len_r <= 10'h000;
         tc_r <= 3'h0;
         attr_r <= 2'h0;
         dig_r <= 1'b0;
         code_r <= 8'h00;
         tag_r <= 16'h0000;
         cnt_r <= 12'h000;
         mps_r <= itmc_pkg::ITMC_MPS_RST;
      end
      else
      begin
         state_r <= state_nxt;
         mps_r <= max_payload_field;
         if (first)
         begin
            ft_r <= rx_data[30:24];
            tc_r <= rx_data[22:20];
            dig_r <= rx_data[15];
            attr_r <= rx_data[13:12];
            len_r <= rx_data[9:0];
            cnt_r <= 12'h001;
         end
         else if (beat)
            cnt_r <= cnt_r + 12'h001;
         if (beat2)
         begin
            tag_r <= {rx_data[31:16]};
            code_r <= rx_data[7:0];
         end
      end
   // verdict and outputs, all registered
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         done_r <= 1'b0;
         bad_r <= 1'b0;
         fatal_r <= 1'b0;
         creq_r <= 1'b0;
         cwr_r <= 1'b0;
         ctag_r <= 16'h0000;
         drop_r <= 1'b0;
         htag_valid_r <= 1'b0;
         htag_r <= 16'h0000;
         sw_r <= 1'b0;
         msi_r <= 1'b0;
      end
      else
      begin
         done_r <= eval;
         bad_r <= eval && len_bad;
         // fatal error pulse per malformed tlp
         fatal_r <= eval && len_bad;
         creq_r <= ok_cfg && !trk_drop;
         cwr_r <= ft_r[6];
         ctag_r <= tag_r;
         drop_r <= trk_drop;
         htag_valid_r <= trk_hv;
         htag_r <= trk_ht;
         sw_r <= port_id == itmc_pkg::ITMC_PORT_UP;
         msi_r <= port_id != itmc_pkg::ITMC_PORT_UP;
      end
   assign tlp_done = done_r;
   assign tlp_malformed = bad_r;
   assign fatal_err = fatal_r;
   assign cfg_req = creq_r;
   assign cfg_write = cwr_r;
   assign cfg_tag = ctag_r;
   assign cfg_drop = drop_r;
   assign cfg_head_valid = htag_valid_r;
   assign cfg_head_tag = htag_r;
   assign has_switch_regs = sw_r;
   assign has_msi_cap = msi_r;
   a_fatal_follows: assert property (@(posedge clk) disable iff (!rst_n)
      (eval && len_bad) |=> fatal_err && tlp_malformed)
      else $error("malformed tlp without fatal");
   a_ok_no_fatal: assert property (@(posedge clk) disable iff (!rst_n)
      (eval && !len_bad) |=> !fatal_err)
      else $error("fatal on good tlp");
   a_cfg_no_bad: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_req |-> $past(eval) && !$past(len_bad))
      else $error("config forwarded after malformed");
   a_msi_layout: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> has_msi_cap != has_switch_regs)
      else $error("capability layout wrong");
   a_cfg_limit: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_drop |-> $past(trk_cnt) == 3'h4)
      else $error("drop below limit");
   a_only_eop: assert property (@(posedge clk) disable iff (!rst_n)
      tlp_done |-> $past(rx_valid && rx_eop))
      else $error("verdict without end of packet");
   c_bad: cover property (@(posedge clk) fatal_err);
   c_cfg: cover property (@(posedge clk) cfg_req);
   c_drop: cover property (@(posedge clk) cfg_drop);
   c_good: cover property (@(posedge clk) tlp_done && !tlp_malformed);
endmodule // itmc_checker

// >>> verilog/itmc_pkg.sv
// package: constants and types for the ingress malformed-packet checker
package itmc_pkg;
   // tlp header format/type codes (fmt[1:0], type[4:0])
   localparam logic [6:0] ITMC_MRD32 = 7'h00;
   localparam logic [6:0] ITMC_MRD64 = 7'h20;
   localparam logic [6:0] ITMC_MWR32 = 7'h40;
   localparam logic [6:0] ITMC_MWR64 = 7'h60;
   localparam logic [6:0] ITMC_IORD = 7'h02;
   localparam logic [6:0] ITMC_IOWR = 7'h42;
   localparam logic [6:0] ITMC_CFGRD0 = 7'h04;
   localparam logic [6:0] ITMC_CFGWR0 = 7'h44;
   localparam logic [6:0] ITMC_CFGRD1 = 7'h05;
   localparam logic [6:0] ITMC_CFGWR1 = 7'h45;
   localparam logic [6:0] ITMC_CPLD = 7'h4A;
   localparam logic [4:0] ITMC_MSG_TYPE = 5'h10;
   // message codes needing tc0
   localparam logic [7:0] ITMC_MC_UNLOCK = 8'h00;
   localparam logic [7:0] ITMC_MC_SLOTPWR = 8'h50;
   localparam logic [3:0] ITMC_MC_INTX_HI = 4'h2;
   localparam logic [3:0] ITMC_MC_ERR_HI = 4'h3;
   localparam logic [7:0] ITMC_MC_PM_NAK = 8'h14;
   localparam logic [7:0] ITMC_MC_PM_PME = 8'h18;
   localparam logic [7:0] ITMC_MC_PM_OFF = 8'h19;
   localparam logic [7:0] ITMC_MC_PM_ACK = 8'h1B;
   // header dword counts and digest extra
   localparam logic [11:0] ITMC_HDR3 = 12'h003;
   localparam logic [11:0] ITMC_HDR4 = 12'h004;
   localparam logic [11:0] ITMC_HDR5 = 12'h005;
   localparam logic [11:0] ITMC_DIG1 = 12'h001;
   localparam logic [9:0] ITMC_LEN_ONE = 10'h001;
   // config tracking, max payload reset value and upstream port id
   localparam int ITMC_CFG_DEPTH = 4;
   localparam logic [2:0] ITMC_CFG_MAX = 3'h4;
   localparam logic [2:0] ITMC_MPS_RST = 3'h0;
   localparam logic [1:0] ITMC_PORT_UP = 2'h0;
   typedef enum logic [1:0] {ITMC_IDLE, ITMC_BODY, ITMC_EVAL} itmc_state_t;
endpackage

// >>> verilog/itmc_len_rule.sv
// leaf: expected received-length check for one tlp
`timescale 1ns/100ps
module itmc_len_rule
(
   // header fields
   input wire logic [6:0] fmt_type,
   input wire logic [9:0] length,
   input wire logic [2:0] tc,
   input wire logic [1:0] attr,
   input wire logic digest,
   input wire logic [7:0] msg_code,
   // measured and limit
   input wire logic [11:0] dw_count,
   input wire logic [11:0] limit_dw,
   // verdict
   output logic bad
);
   wire [11:0] len12 = (length == 10'h000) ? 12'h400 : {2'h0, length};
   wire [11:0] dg = digest ? itmc_pkg::ITMC_DIG1 : 12'h000;
   wire is_io_cfg_rd = fmt_type == itmc_pkg::ITMC_IORD || fmt_type == itmc_pkg::ITMC_CFGRD0
      || fmt_type == itmc_pkg::ITMC_CFGRD1;
   wire is_io_cfg_wr = fmt_type == itmc_pkg::ITMC_IOWR || fmt_type == itmc_pkg::ITMC_CFGWR0
      || fmt_type == itmc_pkg::ITMC_CFGWR1;
   wire is_msg = fmt_type[4:3] == itmc_pkg::ITMC_MSG_TYPE[4:3];
   wire tc0_msg = msg_code == itmc_pkg::ITMC_MC_UNLOCK || msg_code == itmc_pkg::ITMC_MC_SLOTPWR
      || msg_code[7:4] == itmc_pkg::ITMC_MC_INTX_HI || msg_code[7:4] == itmc_pkg::ITMC_MC_ERR_HI
      || msg_code == itmc_pkg::ITMC_MC_PM_NAK || msg_code == itmc_pkg::ITMC_MC_PM_PME
      || msg_code == itmc_pkg::ITMC_MC_PM_OFF || msg_code == itmc_pkg::ITMC_MC_PM_ACK;
   wire bad_mps = len12 >= limit_dw;
   wire bad_fld = (is_io_cfg_rd || is_io_cfg_wr)
      && (length != itmc_pkg::ITMC_LEN_ONE || tc != 3'h0 || attr != 2'h0);
   wire bad_rd = is_io_cfg_rd && dw_count != itmc_pkg::ITMC_HDR3 + dg;
   wire bad_wr = is_io_cfg_wr && dw_count != itmc_pkg::ITMC_HDR4 + dg;
   // memory read counts kept as printed (with digest is the shorter)
   wire bad_mrd = (fmt_type == itmc_pkg::ITMC_MRD32
         && dw_count != (digest ? itmc_pkg::ITMC_HDR3 : itmc_pkg::ITMC_HDR4))
      || (fmt_type == itmc_pkg::ITMC_MRD64
         && dw_count != (digest ? itmc_pkg::ITMC_HDR4 : itmc_pkg::ITMC_HDR5));
   wire bad_mw32 = fmt_type == itmc_pkg::ITMC_MWR32 && dw_count != len12 + itmc_pkg::ITMC_HDR3 + dg;
   wire bad_mw64 = fmt_type == itmc_pkg::ITMC_MWR64 && dw_count != len12 + itmc_pkg::ITMC_HDR4 + dg;
   wire bad_cpl = fmt_type == itmc_pkg::ITMC_CPLD && (dw_count != len12 + itmc_pkg::ITMC_HDR3 + dg
      || dw_count > limit_dw + itmc_pkg::ITMC_HDR3 + dg);
   // message sizes, data length counted only with data
   wire [11:0] mlen = fmt_type[6] ? len12 : 12'h000;
   wire bad_msg = is_msg && (dw_count != mlen + itmc_pkg::ITMC_HDR4 + dg
      || dw_count > limit_dw + itmc_pkg::ITMC_HDR4 + dg);
   wire bad_tc = is_msg && tc0_msg && tc != 3'h0;
   assign bad = bad_mps || bad_fld || bad_rd || bad_wr || bad_mrd || bad_mw32 || bad_mw64
      || bad_cpl || bad_msg || bad_tc;
endmodule // itmc_len_rule

// >>> verilog/itmc_cfg_track.sv
// leaf: in-order tracker of outstanding type 0 config requests
`timescale 1ns/100ps
module itmc_cfg_track
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request in
   input wire logic req_push,
   input wire logic [15:0] req_tag,
   output logic req_drop,
   // completion out
   input wire logic done,
   output logic head_valid,
   output logic [15:0] head_tag,
   output logic [2:0] count
);
   logic [15:0] tag_mem [0:itmc_pkg::ITMC_CFG_DEPTH-1];
   logic [1:0] wp_r;
   logic [1:0] rp_r;
   logic [2:0] cnt_r;
   wire do_pop = done && cnt_r != 3'h0;
   // at most four tracked, excess discarded
   wire full = cnt_r == itmc_pkg::ITMC_CFG_MAX;
   wire do_push = req_push && !full;
   assign req_drop = req_push && full;
   assign head_valid = cnt_r != 3'h0;
   assign head_tag = tag_mem[rp_r];
   assign count = cnt_r;
   always_ff @(posedge clk)
      if (do_push)
         tag_mem[wp_r] <= req_tag;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         wp_r <= 2'h0;
         rp_r <= 2'h0;
         cnt_r <= 3'h0;
      end
      else
      begin
         wp_r <= wp_r + 2'(do_push);
         rp_r <= rp_r + 2'(do_pop);
         cnt_r <= cnt_r + 3'(do_push) - 3'(do_pop);
      end
   a_cnt_bound: assert property (@(posedge clk) disable iff (!rst_n) cnt_r <= 3'h4)
      else $error("config tracker above four");
   a_drop_full: assert property (@(posedge clk) disable iff (!rst_n)
      req_drop |-> cnt_r == 3'h4)
      else $error("drop while not full");
endmodule // itmc_cfg_track

// >>> bench/itmc_link_partner.sv
// link partner model: sends tlps to the port, one dword per beat
`timescale 1ns/100ps
module itmc_link_partner
(
   // clock
   input wire logic clk,
   // tlp stream toward the port
   output logic rx_valid,
   output logic rx_sop,
   output logic rx_eop,
   output logic [31:0] rx_data
);
   initial
   begin
      rx_valid = 1'b0;
      rx_sop = 1'b0;
      rx_eop = 1'b0;
      rx_data = 32'h5A5A_5A5A;
   end
   // returns 1 ns after the edge that takes the eop beat
   task automatic send(input logic [31:0] hdr, input logic [31:0] second, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         #1;
         rx_valid = 1'b1;
         rx_sop = (i == 0);
         rx_eop = (i == n - 1);
         rx_data = (i == 0) ? hdr : (i == 1) ? second : 32'hC0DE_0000 + 32'(i);
      end
      @(posedge clk);
      #1;
      // idle data flips so a stale dword is never mistaken for a beat
      rx_valid = 1'b0;
      rx_sop = 1'b0;
      rx_eop = 1'b0;
      rx_data = ~rx_data;
   endtask
endmodule // itmc_link_partner

// >>> bench/itmc_checker_tb_top.sv
// testbench: ingress malformed checker driven by the link partner model
`timescale 1ns/100ps
module itmc_checker_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] port_id = 2'h0;
   logic [2:0] max_payload_field = 3'h0;
   logic cfg_done = 1'b0;
   logic rx_valid, rx_sop, rx_eop, tlp_done, tlp_malformed, fatal_err;
   logic cfg_req, cfg_write, cfg_drop, cfg_head_valid, has_switch_regs, has_msi_cap;
   logic [31:0] rx_data;
   logic [15:0] cfg_tag, cfg_head_tag;
   logic [15:0] next_tag = 16'h0100;
   int n_out = 0;
   int n_mismatch = 0;
   int n_checks = 0;
   always #10 clk = ~clk;
   itmc_checker i_dut (.clk(clk), .rst_n(rst_n), .port_id(port_id),
      .max_payload_field(max_payload_field), .rx_valid(rx_valid), .rx_sop(rx_sop),
      .rx_eop(rx_eop), .rx_data(rx_data), .tlp_done(tlp_done), .tlp_malformed(tlp_malformed),
      .fatal_err(fatal_err), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_tag(cfg_tag),
      .cfg_drop(cfg_drop), .cfg_done(cfg_done), .cfg_head_tag(cfg_head_tag),
      .cfg_head_valid(cfg_head_valid), .has_switch_regs(has_switch_regs),
      .has_msi_cap(has_msi_cap));
   itmc_link_partner i_peer (.clk(clk), .rx_valid(rx_valid), .rx_sop(rx_sop),
      .rx_eop(rx_eop), .rx_data(rx_data));
   task automatic chk(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_tag(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one tlp; a good type 0 config request is forwarded unless four are held
   task automatic tlp(input logic [6:0] ft, input logic [9:0] len, input logic [2:0] tc,
      input logic [1:0] at, input logic dg, input logic [7:0] mc, input int n, input logic bad);
      logic is_cfg;
      is_cfg = !bad && (ft == itmc_pkg::ITMC_CFGRD0 || ft == itmc_pkg::ITMC_CFGWR0);
      i_peer.send({1'b0, ft, 1'b0, tc, 4'h0, dg, 1'b0, at, 2'h0, len}, {next_tag, 8'h00, mc}, n);
      chk("tlp_done", 1'b1, tlp_done);
      chk("tlp_malformed", bad, tlp_malformed);
      chk("fatal_err", bad, fatal_err);
      chk("cfg_req", is_cfg && n_out < 4, cfg_req);
      chk("cfg_drop", is_cfg && n_out == 4, cfg_drop);
      if (is_cfg && n_out < 4)
      begin
         chk("cfg_write", ft == itmc_pkg::ITMC_CFGWR0, cfg_write);
         chk_tag("cfg_tag", next_tag, cfg_tag);
         n_out++;
      end
      next_tag++;
   endtask
   task automatic cfg_complete;
      @(posedge clk);
      #1 cfg_done = 1'b1;
      @(posedge clk);
      #1 cfg_done = 1'b0;
      n_out--;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic test_io_cfg;
      tlp(itmc_pkg::ITMC_IORD, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 3, 1'b0);
      tlp(itmc_pkg::ITMC_IORD, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 4, 1'b0);
      tlp(itmc_pkg::ITMC_IORD, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 3, 1'b1);
      tlp(itmc_pkg::ITMC_IOWR, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 4, 1'b0);
      tlp(itmc_pkg::ITMC_IOWR, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 5, 1'b0);
      tlp(itmc_pkg::ITMC_IOWR, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 5, 1'b1);
      tlp(itmc_pkg::ITMC_IORD, 10'h001, 3'h2, 2'h0, 1'b0, 8'h00, 3, 1'b1);
      tlp(itmc_pkg::ITMC_CFGRD0, 10'h002, 3'h0, 2'h0, 1'b0, 8'h00, 3, 1'b1);
      tlp(itmc_pkg::ITMC_CFGRD0, 10'h001, 3'h1, 2'h0, 1'b0, 8'h00, 3, 1'b1);
      tlp(itmc_pkg::ITMC_CFGWR0, 10'h001, 3'h0, 2'h1, 1'b0, 8'h00, 4, 1'b1);
      tlp(itmc_pkg::ITMC_CFGRD0, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 4, 1'b0);
      tlp(itmc_pkg::ITMC_CFGWR0, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 4, 1'b0);
      cfg_complete();
      cfg_complete();
      $display("test_io_cfg done");
   endtask
   task automatic test_mem;
      tlp(itmc_pkg::ITMC_MRD32, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 4, 1'b0);
      tlp(itmc_pkg::ITMC_MRD32, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 3, 1'b0);
      tlp(itmc_pkg::ITMC_MRD32, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 3, 1'b1);
      tlp(itmc_pkg::ITMC_MRD64, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 5, 1'b0);
      tlp(itmc_pkg::ITMC_MRD64, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 4, 1'b0);
      tlp(itmc_pkg::ITMC_MRD64, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 4, 1'b1);
      tlp(itmc_pkg::ITMC_MWR32, 10'h002, 3'h0, 2'h0, 1'b0, 8'h00, 5, 1'b0);
      tlp(itmc_pkg::ITMC_MWR32, 10'h002, 3'h0, 2'h0, 1'b1, 8'h00, 6, 1'b0);
      tlp(itmc_pkg::ITMC_MWR32, 10'h002, 3'h0, 2'h0, 1'b0, 8'h00, 6, 1'b1);
      tlp(itmc_pkg::ITMC_MWR64, 10'h002, 3'h0, 2'h0, 1'b0, 8'h00, 6, 1'b0);
      tlp(itmc_pkg::ITMC_MWR64, 10'h002, 3'h0, 2'h0, 1'b1, 8'h00, 7, 1'b0);
      tlp(itmc_pkg::ITMC_MWR64, 10'h002, 3'h0, 2'h0, 1'b0, 8'h00, 5, 1'b1);
      $display("test_mem done");
   endtask
   task automatic test_cpl_msg;
      tlp(itmc_pkg::ITMC_CPLD, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 4, 1'b0);
      tlp(itmc_pkg::ITMC_CPLD, 10'h001, 3'h0, 2'h0, 1'b1, 8'h00, 5, 1'b0);
      tlp(itmc_pkg::ITMC_CPLD, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 5, 1'b1);
      tlp(7'h70, 10'h001, 3'h0, 2'h0, 1'b0, 8'h7E, 5, 1'b0);
      tlp(7'h70, 10'h001, 3'h0, 2'h0, 1'b1, 8'h7E, 6, 1'b0);
      tlp(7'h70, 10'h001, 3'h0, 2'h0, 1'b0, 8'h7E, 6, 1'b1);
      $display("test_cpl_msg done");
   endtask
   task automatic test_tc0_msgs;
      logic [7:0] codes [8] = '{8'h00, 8'h50, 8'h20, 8'h30, 8'h14, 8'h18, 8'h19, 8'h1B};
      for (int i = 0; i < 8; i++)
         tlp(7'h70, 10'h001, 3'h1, 2'h0, 1'b0, codes[i], 5, 1'b1);
      tlp(7'h70, 10'h001, 3'h0, 2'h0, 1'b0, 8'h20, 5, 1'b0);
      tlp(7'h70, 10'h001, 3'h1, 2'h0, 1'b0, 8'h7E, 5, 1'b0);
      $display("test_tc0_msgs done");
   endtask
   task automatic test_payload_limit;
      tlp(itmc_pkg::ITMC_MWR32, 10'h07F, 3'h0, 2'h0, 1'b0, 8'h00, 130, 1'b0);
      tlp(itmc_pkg::ITMC_MWR32, 10'h080, 3'h0, 2'h0, 1'b0, 8'h00, 131, 1'b1);
      #1 max_payload_field = 3'h1;
      tlp(itmc_pkg::ITMC_MWR32, 10'h080, 3'h0, 2'h0, 1'b0, 8'h00, 131, 1'b0);
      #1 max_payload_field = 3'h0;
      $display("test_payload_limit done");
   endtask
   task automatic test_cfg_track;
      logic [15:0] first;
      first = next_tag;
      // four reads is the legal ceiling; the fifth breaks it on purpose
      // no type 1 access is sent while a config write is pending
      for (int i = 0; i < 5; i++)
         tlp(itmc_pkg::ITMC_CFGRD0, 10'h001, 3'h0, 2'h0, 1'b0, 8'h00, 3, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++)
      begin
         chk("cfg_head_valid", 1'b1, cfg_head_valid);
         chk_tag("cfg_head_tag", first + 16'(i), cfg_head_tag);
         cfg_complete();
      end
      chk("cfg_head_valid", 1'b0, cfg_head_valid);
      $display("test_cfg_track done");
   endtask
   task automatic test_layout;
      for (int p = 0; p < 3; p++)
      begin
         port_id = 2'(p);
         repeat (2) @(posedge clk);
         #1;
         chk("has_switch_regs", p == 0, has_switch_regs);
         chk("has_msi_cap", p != 0, has_msi_cap);
      end
      port_id = 2'h0;
      $display("test_layout done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      test_layout();
      test_io_cfg();
      test_mem();
      test_cpl_msg();
      test_tc0_msgs();
      test_payload_limit();
      test_cfg_track();
      report_and_stop();
   end
   // about 680 cycles of traffic expected; over twenty times that is a hang
   initial
   begin
      #300000;
      n_mismatch++;
      report_and_stop();
   end
endmodule // itmc_checker_tb_top
